// ---- logic/pep_pkg.sv ----
// Constants and types shared by the port E pin block.
// Assumes a 32-bit AHB-Lite register bus and one core clock.
package pep_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [31:0] PEP_OFF_PIN_VALUES  = 32'h0000_0000; // Pin values
  localparam logic [31:0] PEP_OFF_OUT_LATCH   = 32'h0000_0004; // Output latch
  localparam logic [31:0] PEP_OFF_DIRECTION   = 32'h0000_0008; // Direction
  localparam logic [31:0] PEP_OFF_ANALOG_CFG  = 32'h0000_000c; // Analog pin config
  localparam logic [31:0] PEP_ADDR_MASK       = 32'h0000_000f; // Decoded offset bits

  // ----------------------------------------------------------------
  // Widths and field positions
  // ----------------------------------------------------------------
  localparam int          PEP_NUM_BIDIR       = 3;      // Bidirectional pins
  localparam int          PEP_REG_W           = 8;      // Register width
  localparam int          PEP_INONLY_POS      = 3;      // Input-only bit position
  localparam int          PEP_SEL_LSB         = 0;      // Analog select field LSB
  localparam int          PEP_SEL_MSB         = 3;      // Analog select field MSB
  localparam int          PEP_REF_LSB         = 4;      // Reference select LSB
  localparam int          PEP_REF_MSB         = 5;      // Reference select MSB
  localparam logic [7:0]  PEP_ANA_CFG_MASK    = 8'h3f;  // Implemented config bits

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  PEP_LATCH_RST       = 3'h0;   // Latches cleared
  localparam logic [2:0]  PEP_DIR_RST         = 3'h7;   // All pins input
  localparam logic [7:0]  PEP_ANA_CFG_RST     = 8'h00;  // All channels analog

  // ----------------------------------------------------------------
  // Analog channel decode
  // ----------------------------------------------------------------
  localparam logic [4:0]  PEP_CHAN_BASE       = 5'h05;  // First channel number
  localparam logic [4:0]  PEP_CHAN_LIMIT      = 5'h0e;  // Channel analog if sel <= limit - ch

  // ----------------------------------------------------------------
  // AHB-Lite encodings
  // ----------------------------------------------------------------
  localparam logic [1:0]  PEP_HTRANS_NONSEQ   = 2'h2;   // Only transfer type used
  localparam logic        PEP_HRESP_OKAY      = 1'h0;   // Always OKAY

  // Synchronised external inputs, one bundle per stage
  typedef struct packed {
    logic       hvDetect;      // High-voltage detect comparator
    logic       masterClearCfg;// Master clear select configuration
    logic       fullPort;      // Full port package strap
    logic       inputOnly;     // Input-only pin level
    logic [2:0] bidir;         // Bidirectional pin levels
  } pep_pins_s;

endpackage

// ---- logic/pep_port_e_pin_io.sv ----
// Port E pin block: three bidirectional pins, one input-only pin,
// four registers on an AHB-Lite slave.
// Assumes all pin and configuration inputs are asynchronous to ref_clk.
//
// Behaviour
// RULE1: Bit 3 reads pin only with master clear off
// RULE2: Small package: only input-only bit, if enabled
// RULE3: Small package: bidir, latch, direction read zero
// RULE4: Direction 0 drives latch, analog mode irrelevant
// RULE5: Direction 1 samples pin; analog disables input
// RULE6: Reset leaves three pins as analog inputs
// RULE7: Software keeps analog pins set as inputs
// RULE8: No direction bit 3; pin always input
// RULE9: Master clear select makes pin reset input
// RULE10: High-voltage detect always active on pin
// RULE11: Writing pin register updates output latches
// RULE12: Bidir bits exist only on full port
// RULE13: Analog-selected pin reads zero
// RULE14: Direction 1 tristates, 0 drives latch
// RULE15: Latch register reads latched value, not pin
// RULE16: Pin inputs synchronised before reading
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module pep_port_e_pin_io (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  // Bidirectional pins
  input  wire logic [2:0]          pinIn,
  output logic [2:0]               pinOut,
  output logic [2:0]               pinOe_n,
  // Input-only pin and its side functions
  input  wire logic                inputOnlyPin,
  input  wire logic                hvDetectIn,
  output logic                     masterClearAssert,
  output logic                     progEntryDetect,
  // Configuration straps
  input  wire logic                masterClearSelectCfg,
  input  wire logic                fullPortCfg,
  // Analog converter channel enables (channels 5, 6, 7)
  output logic [2:0]               analogChanEn
);
  import pep_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0]        rstPipe_q;     // Reset release synchroniser
  logic              rstSync_n;     // Synchronised reset
  pep_pins_s         syncA_q;       // First sync stage
  pep_pins_s         syncB_q;       // Second sync stage, used by logic
  pep_pins_s         pinsRaw;       // Raw input bundle
  logic [2:0]        latch_q;       // Output latch
  logic [2:0]        latch_d;
  logic [2:0]        dir_q;         // Direction, 1 = input
  logic [2:0]        dir_d;
  logic [7:0]        anaCfg_q;      // Analog pin config
  logic [7:0]        anaCfg_d;
  logic              dpWrite_q;     // Write data phase pending
  logic [31:0]       dpAddr_q;      // Data phase address
  logic [31:0]       hrdata_q;      // Registered read data
  logic              addrPhase;     // Address phase accepted
  logic              rdTake;        // Read accepted
  logic              wrPin;         // Data phase write to pin values
  logic              wrLatch;       // Data phase write to latch
  logic              wrDir;         // Data phase write to direction
  logic              wrAna;         // Data phase write to analog config
  logic              full;          // Full port variant
  logic [2:0]        analogSel;     // Pins in analog mode
  logic [2:0]        bidirRead;     // Bidir bits as read
  logic              inOnlyRead;    // Input-only bit as read
  logic [7:0]        pinValRead;    // Pin values register view
  logic [7:0]        latchRead;     // Latch register view
  logic [7:0]        dirRead;       // Direction register view
  logic [31:0]       rdMux;         // Selected read word

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // True when an address hits the given register offset
  function automatic logic hitReg(input logic [31:0] addr, input logic [31:0] off);
    hitReg = ((addr & ~PEP_ADDR_MASK) == 32'h0) && ((addr & PEP_ADDR_MASK) == off);
  endfunction

  // Analog mode of one channel from the select field
  function automatic logic chanAnalog(input logic [3:0] sel, input logic [4:0] chan);
    logic [4:0] lim;
    lim = PEP_CHAN_LIMIT - chan;
    chanAnalog = ({1'b0, sel} <= lim);
  endfunction

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  // Assert at once, release after two edges
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rstPipe_q <= 2'h0;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end
  assign rstSync_n = rstPipe_q[1];

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  assign pinsRaw = '{hvDetect:       hvDetectIn,
                     masterClearCfg: masterClearSelectCfg,
                     fullPort:       fullPortCfg,
                     inputOnly:      inputOnlyPin,
                     bidir:          pinIn};

  // Two flops; only the second stage feeds logic
  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      syncA_q <= '0;
      syncB_q <= '0;
    end else begin
      syncA_q <= pinsRaw;                                     // RULE16
      syncB_q <= syncA_q;                                     // RULE16
    end
  end
  assign full = syncB_q.fullPort;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign addrPhase = hsel && hready && (htrans == PEP_HTRANS_NONSEQ);
  assign rdTake    = addrPhase && !hwrite;
  assign wrPin     = dpWrite_q && hitReg(dpAddr_q, PEP_OFF_PIN_VALUES);
  assign wrLatch   = dpWrite_q && hitReg(dpAddr_q, PEP_OFF_OUT_LATCH);
  assign wrDir     = dpWrite_q && hitReg(dpAddr_q, PEP_OFF_DIRECTION);
  assign wrAna     = dpWrite_q && hitReg(dpAddr_q, PEP_OFF_ANALOG_CFG);

  // Register next values; small package ignores latch/direction writes
  assign latch_d  = (full && (wrPin || wrLatch)) ? hwdata[2:0] : latch_q;  // RULE11 RULE3
  assign dir_d    = (full && wrDir) ? hwdata[2:0] : dir_q;                 // RULE8 RULE3
  assign anaCfg_d = wrAna ? (hwdata[7:0] & PEP_ANA_CFG_MASK) : anaCfg_q;

  // Address phase capture
  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      dpWrite_q <= 1'b0;
      dpAddr_q  <= 32'h0;
    end else begin
      dpWrite_q <= addrPhase && hwrite;
      dpAddr_q  <= addrPhase ? haddr : dpAddr_q;
    end
  end

  // ----------------------------------------------------------------
  // Port registers
  // ----------------------------------------------------------------
  // Latch, direction and analog config
  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      latch_q  <= PEP_LATCH_RST;
      dir_q    <= PEP_DIR_RST;
      anaCfg_q <= PEP_ANA_CFG_RST;                            // RULE6
    end else begin
      latch_q  <= latch_d;
      dir_q    <= dir_d;
      anaCfg_q <= anaCfg_d;
    end
  end

  // ----------------------------------------------------------------
  // Analog select and pin drive
  // ----------------------------------------------------------------
  // Channels 5, 6, 7 map to pins 0, 1, 2
  generate
    for (genvar k = 0; k < PEP_NUM_BIDIR; k++) begin : g_chan
      assign analogSel[k] = full &&
        chanAnalog(anaCfg_q[PEP_SEL_MSB:PEP_SEL_LSB], PEP_CHAN_BASE + 5'(k)); // RULE6
    end
  endgenerate
  assign analogChanEn = analogSel;

  // Output enable low drives; analog mode does not touch the driver
  assign pinOe_n = ~(~dir_q & {3{full}});                     // RULE4 RULE14 RULE7
  assign pinOut  = latch_q & {3{full}};                       // RULE4

  // ----------------------------------------------------------------
  // Input-only pin functions
  // ----------------------------------------------------------------
  // Active-low reset input when selected
  assign masterClearAssert = syncB_q.masterClearCfg && !syncB_q.inputOnly; // RULE9
  // Detection stays live whatever the pin mode
  assign progEntryDetect   = syncB_q.hvDetect;                // RULE10

  // ----------------------------------------------------------------
  // Read views
  // ----------------------------------------------------------------
  // Pin bits read zero when analog or absent
  assign bidirRead  = syncB_q.bidir & ~analogSel & {3{full}}; // RULE5 RULE13 RULE12
  // Input-only bit only without master clear
  assign inOnlyRead = syncB_q.inputOnly && !syncB_q.masterClearCfg;   // RULE1 RULE2
  assign pinValRead = {4'h0, inOnlyRead, bidirRead};
  // Latch view is the latch itself, never the pin
  assign latchRead  = {5'h00, latch_d & {3{full}}};           // RULE15 RULE3
  assign dirRead    = {5'h00, dir_d & {3{full}}};             // RULE8 RULE3

  // Read mux; post-write values forward a pending write
  assign rdMux = hitReg(haddr, PEP_OFF_PIN_VALUES) ? {24'h0, pinValRead} :
                 hitReg(haddr, PEP_OFF_OUT_LATCH)  ? {24'h0, latchRead}  :
                 hitReg(haddr, PEP_OFF_DIRECTION)  ? {24'h0, dirRead}    :
                 hitReg(haddr, PEP_OFF_ANALOG_CFG) ? {24'h0, anaCfg_d}   :
                 32'h0;

  // Read data held until the next read
  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      hrdata_q <= 32'h0;
    end else begin
      hrdata_q <= rdTake ? rdMux : hrdata_q;
    end
  end

  // Zero wait states, always OKAY
  assign hrdata    = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = PEP_HRESP_OKAY;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Read of a given register in address phase
  sequence s_readPin;
    rdTake && hitReg(haddr, PEP_OFF_PIN_VALUES);
  endsequence
  sequence s_readLatDir;
    rdTake && (hitReg(haddr, PEP_OFF_OUT_LATCH) || hitReg(haddr, PEP_OFF_DIRECTION));
  endsequence

  property p_inOnlyRead;
    @(posedge ref_clk) disable iff (!rstSync_n)
    s_readPin |=> hrdata[PEP_INONLY_POS] ==
      ($past(syncB_q.inputOnly) && !$past(syncB_q.masterClearCfg));
  endproperty
  a_inOnlyRead: assert property (p_inOnlyRead)                // RULE1
    else $error("input-only bit read wrong");

  property p_smallPinRead;
    @(posedge ref_clk) disable iff (!rstSync_n)
    (s_readPin and !full) |=> hrdata[2:0] == 3'h0 && hrdata[31:4] == 28'h0;
  endproperty
  a_smallPinRead: assert property (p_smallPinRead)            // RULE2
    else $error("small package pin bits not zero");

  property p_smallLatDir;
    @(posedge ref_clk) disable iff (!rstSync_n)
    (s_readLatDir and !full) |=> hrdata == 32'h0;
  endproperty
  a_smallLatDir: assert property (p_smallLatDir)              // RULE3
    else $error("small package latch or direction not zero");

  property p_latchDrive;
    @(posedge ref_clk) disable iff (!rstSync_n)
    (wrLatch && full) |=> pinOut == $past(hwdata[2:0]);
  endproperty
  a_latchDrive: assert property (p_latchDrive)                // RULE4
    else $error("pin output does not follow latch write");

  property p_pinRead;
    @(posedge ref_clk) disable iff (!rstSync_n)
    s_readPin |=> hrdata[2:0] == ($past(syncB_q.bidir) & ~$past(analogSel) & {3{$past(full)}});
  endproperty
  a_pinRead: assert property (p_pinRead)                      // RULE5
    else $error("bidirectional read wrong");

  property p_analogReset;
    @(posedge ref_clk)
    ($rose(rstSync_n) ##2 full) |-> analogChanEn == 3'h7;
  endproperty
  a_analogReset: assert property (p_analogReset)              // RULE6
    else $error("pins not analog after reset");

  property p_dirTristate;
    @(posedge ref_clk) disable iff (!rstSync_n)
    (wrDir && full) |=> pinOe_n == $past(hwdata[2:0]);
  endproperty
  a_dirTristate: assert property (p_dirTristate)              // RULE14
    else $error("output enable does not follow direction write");

  property p_masterClear;
    @(posedge ref_clk) disable iff (!rstSync_n)
    masterClearAssert |-> syncB_q.masterClearCfg && !inOnlyRead;
  endproperty
  a_masterClear: assert property (p_masterClear)              // RULE9
    else $error("master clear without select");

  property p_hvDetect;
    @(posedge ref_clk) disable iff (!rstSync_n)
    $past(rstSync_n, 2) |-> progEntryDetect == $past(hvDetectIn, 2);
  endproperty
  a_hvDetect: assert property (p_hvDetect)                    // RULE10
    else $error("high-voltage detect not passed through");

  property p_pinWriteLatch;
    @(posedge ref_clk) disable iff (!rstSync_n)
    (wrPin && full) |=> latch_q == $past(hwdata[2:0]) ##1 1'b1;
  endproperty
  a_pinWriteLatch: assert property (p_pinWriteLatch)          // RULE11
    else $error("pin register write did not update latch");

  property p_latchReadback;
    @(posedge ref_clk) disable iff (!rstSync_n)
    (rdTake && hitReg(haddr, PEP_OFF_OUT_LATCH) && full) |=> hrdata[2:0] == latch_q;
  endproperty
  a_latchReadback: assert property (p_latchReadback)          // RULE15
    else $error("latch readback is not the latch");

  // Direction register has no bit for the input-only pin
  property p_dirNoBit3;
    @(posedge ref_clk) disable iff (!rstSync_n)
    (rdTake && hitReg(haddr, PEP_OFF_DIRECTION)) |=>
      hrdata[PEP_REG_W-1:PEP_INONLY_POS] == 5'h00;
  endproperty
  a_dirNoBit3: assert property (p_dirNoBit3)                  // RULE8
    else $error("direction register shows a bit 3");

  // Analog pins read zero in the pin values register
  property p_analogZero;
    @(posedge ref_clk) disable iff (!rstSync_n)
    s_readPin |=> (hrdata[2:0] & $past(analogSel)) == 3'h0;
  endproperty
  a_analogZero: assert property (p_analogZero)                // RULE13
    else $error("analog pin does not read zero");

  // Pin read shows the pin level two edges before the address phase
  property p_pinSync;
    @(posedge ref_clk) disable iff (!rstSync_n)
    (s_readPin and $past(rstSync_n, 2)) |=>
      hrdata[2:0] == ($past(pinIn, 3) & ~$past(analogSel) & {3{$past(full)}});
  endproperty
  a_pinSync: assert property (p_pinSync)                      // RULE16
    else $error("pin read not two stages behind the pin");

  // Small package keeps the bidirectional pins idle
  property p_smallIdle;
    @(posedge ref_clk) disable iff (!rstSync_n)
    !full |-> analogChanEn == 3'h0 && pinOe_n == 3'h7 && pinOut == 3'h0;
  endproperty
  a_smallIdle: assert property (p_smallIdle)                  // RULE12
    else $error("bidirectional pin active on small package");

endmodule

// ---- test/pep_board_model.sv ----
// Board-side model of the three bidirectional port pins.
// Assumes the bench sets the board's own levels; the design drives through pinOut/pinOe_n.
`timescale 1ns/1ps

module pep_board_model (
  // Design side of the pins
  input  wire logic [2:0] pinOut,
  input  wire logic [2:0] pinOe_n,
  // Board levels and resolved wire level
  input  wire logic [2:0] boardLevel,
  output logic [2:0]      pinIn
);
  // --------------------------------------------------------------
  // Wire resolution
  // --------------------------------------------------------------
  // Design wins where it drives, board elsewhere; no contention modelled
  assign pinIn = (pinOe_n & boardLevel) | (~pinOe_n & pinOut);
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the port E pin block.
// Assumes one 25 MHz clock, a zero-wait AHB-Lite slave and the board model.
`timescale 1ns/1ps

module tb_top;
  import pep_pkg::*;

  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic        ref_clk;              // Core clock
  logic        nrst;                 // Reset, active low
  logic        hsel;                 // Bus select
  logic [31:0] haddr;                // Bus address
  logic [1:0]  htrans;               // Transfer type
  logic        hwrite;               // Write flag
  logic [2:0]  hsize;                // Transfer size
  logic [31:0] hwdata;               // Write data
  logic        hready;               // Bus ready
  logic        hreadyout;            // Slave ready
  logic        hresp;                // Slave response
  logic [31:0] hrdata;               // Read data
  logic [2:0]  pinIn;                // Resolved pin levels
  logic [2:0]  pinOut;               // Driven pin levels
  logic [2:0]  pinOe_n;              // Drive enables, low drives
  logic [2:0]  boardLevel;           // Board's own levels
  logic        inputOnlyPin;         // Input-only pin level
  logic        hvDetectIn;           // High-voltage comparator
  logic        masterClearAssert;    // Master clear out
  logic        progEntryDetect;      // Programming entry out
  logic        masterClearSelectCfg; // Master clear strap
  logic        fullPortCfg;          // Package strap
  logic [2:0]  analogChanEn;         // Analog channel enables
  logic [31:0] rdata;                // Last read data
  int          error_cnt;            // Mismatches
  int          compares;             // Comparisons made
  logic [7:0]  selTab [4] = '{8'h07, 8'h08, 8'h09, 8'h0a}; // Select field values
  logic [2:0]  anaTab [4] = '{3'h7, 3'h3, 3'h1, 3'h0};     // Expected analog pins

  assign hready = hreadyout;

  // --------------------------------------------------------------
  // Instances
  // --------------------------------------------------------------
  pep_port_e_pin_io pep_port_e_pin_io_i (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n), .inputOnlyPin(inputOnlyPin),
    .hvDetectIn(hvDetectIn), .masterClearAssert(masterClearAssert),
    .progEntryDetect(progEntryDetect), .masterClearSelectCfg(masterClearSelectCfg),
    .fullPortCfg(fullPortCfg), .analogChanEn(analogChanEn));
  pep_board_model pep_board_model_i (.pinOut(pinOut), .pinOe_n(pinOe_n),
    .boardLevel(boardLevel), .pinIn(pinIn));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // Clock, 40 ns period
  always #20 ref_clk = ~ref_clk;

  // Verdict and end of run
  task summarize();
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask

  // One single transfer, held until hready is seen high
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel   <= 1'b1;
    htrans <= PEP_HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'h2;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    rdata = hrdata;
    chk(32'(hresp), 32'(PEP_HRESP_OKAY));
    if (n >= 20) begin
      error_cnt++;
      summarize();
    end
  endtask

  // Register write, and register read with compare
  task wrReg(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdChk(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask

  // Let asynchronous inputs pass the synchronisers
  task settle();
    repeat (4) @(posedge ref_clk);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  // Values straight after reset
  task tReset();
    rdChk(PEP_OFF_OUT_LATCH, 32'h0);
    rdChk(PEP_OFF_DIRECTION, 32'h7);
    rdChk(PEP_OFF_ANALOG_CFG, 32'h0);
    chk(32'(analogChanEn), 32'h7);
    chk(32'(pinOe_n), 32'h7);
    rdChk(PEP_OFF_PIN_VALUES, 32'h0);
  endtask

  // Drive from the latch, then tristate and read the board
  task tDrive();
    wrReg(PEP_OFF_ANALOG_CFG, 32'h0a);
    wrReg(PEP_OFF_PIN_VALUES, 32'h5);
    wrReg(PEP_OFF_DIRECTION, 32'h0);
    settle();
    chk(32'(pinOe_n), 32'h0);
    chk(32'(pinOut), 32'h5);
    boardLevel <= 3'h2;
    wrReg(PEP_OFF_DIRECTION, 32'h7);
    settle();
    chk(32'(pinOe_n), 32'h7);
    rdChk(PEP_OFF_OUT_LATCH, 32'h5);
    rdChk(PEP_OFF_PIN_VALUES, 32'h2);
    wrReg(PEP_OFF_PIN_VALUES, 32'h0);
    rdChk(PEP_OFF_OUT_LATCH, 32'h0);
  endtask

  // Analog selection keeps the driver, blanks the read path
  task tAnalog();
    wrReg(PEP_OFF_OUT_LATCH, 32'h6);
    wrReg(PEP_OFF_DIRECTION, 32'h0);
    wrReg(PEP_OFF_ANALOG_CFG, 32'h0);
    settle();
    chk(32'(pinOut), 32'h6);
    chk(32'(analogChanEn), 32'h7);
    wrReg(PEP_OFF_DIRECTION, 32'h7);
    wrReg(PEP_OFF_ANALOG_CFG, 32'hff);
    rdChk(PEP_OFF_ANALOG_CFG, 32'(PEP_ANA_CFG_MASK));
    for (int i = 0; i < 4; i++) begin
      wrReg(PEP_OFF_ANALOG_CFG, 32'(selTab[i]));
      settle();
      chk(32'(analogChanEn), 32'(anaTab[i]));
      rdChk(PEP_OFF_PIN_VALUES, {29'h0, 3'h2 & ~anaTab[i]});
    end
  endtask

  // Input-only pin, master clear and high-voltage detect
  task tInputOnly();
    inputOnlyPin <= 1'b1;
    hvDetectIn   <= 1'b1;
    settle();
    rdChk(PEP_OFF_PIN_VALUES, 32'ha);
    chk(32'(progEntryDetect), 32'h1);
    masterClearSelectCfg <= 1'b1;
    settle();
    rdChk(PEP_OFF_PIN_VALUES, 32'h2);
    chk(32'(masterClearAssert), 32'h0);
    inputOnlyPin <= 1'b0;
    hvDetectIn   <= 1'b0;
    settle();
    chk(32'(masterClearAssert), 32'h1);
    chk(32'(progEntryDetect), 32'h0);
    wrReg(PEP_OFF_DIRECTION, 32'hff);
    rdChk(PEP_OFF_DIRECTION, 32'h7);
    wrReg(32'h10, 32'hff);
    rdChk(32'h10, 32'h0);
    rdChk(PEP_OFF_OUT_LATCH, 32'h6);
    masterClearSelectCfg <= 1'b0;
  endtask

  // Smallest package: only the input-only bit remains
  task tSmall();
    fullPortCfg  <= 1'b0;
    inputOnlyPin <= 1'b1;
    boardLevel   <= 3'h7;
    settle();
    wrReg(PEP_OFF_OUT_LATCH, 32'h7);
    wrReg(PEP_OFF_DIRECTION, 32'h0);
    rdChk(PEP_OFF_OUT_LATCH, 32'h0);
    rdChk(PEP_OFF_DIRECTION, 32'h0);
    settle();
    chk(32'(pinOe_n), 32'h7);
    chk(32'(pinOut), 32'h0);
    chk(32'(analogChanEn), 32'h0);
    rdChk(PEP_OFF_PIN_VALUES, 32'h8);
    masterClearSelectCfg <= 1'b1;
    settle();
    rdChk(PEP_OFF_PIN_VALUES, 32'h0);
  endtask

  // Reset in mid-run brings the port back to its power-on state
  task tMidReset();
    fullPortCfg          <= 1'b1;
    masterClearSelectCfg <= 1'b0;
    inputOnlyPin         <= 1'b0;
    settle();
    wrReg(PEP_OFF_OUT_LATCH, 32'h5);
    wrReg(PEP_OFF_DIRECTION, 32'h0);
    wrReg(PEP_OFF_ANALOG_CFG, 32'h0a);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    settle();
    tReset();
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    boardLevel = 3'h7;
    inputOnlyPin = 1'b0;
    hvDetectIn = 1'b0;
    masterClearSelectCfg = 1'b0;
    fullPortCfg = 1'b1;
    error_cnt = 0;
    compares = 0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    settle();
    tReset();
    tDrive();
    tAnalog();
    tInputOnly();
    tSmall();
    tMidReset();
    summarize();
  end
endmodule
